// ==== rtl/modbus_pkg.sv ====
// Shared constants, frame layout, state type and checksum step for the RTU slave
package modbus_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BAUD_BPS = 2400;
    localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
    localparam int unsigned START_BITS = 1;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned STOP_BITS = 2;
    localparam int unsigned CHAR_BITS = START_BITS + DATA_BITS + STOP_BITS;
    localparam int unsigned GAP_HALF_CHARS = 3;
    localparam int CW = 24;
    // Addresses and function codes
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WR_ONE = 8'h06;
    localparam logic [7:0] FC_WR_MANY = 8'h10;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    // Frame layout
    localparam logic [7:0] MAX_FRAME = 8'hFF;
    localparam logic [7:0] MIN_FRAME = 8'h04;
    localparam logic [7:0] POS_FC = 8'h01;
    localparam logic [7:0] POS_DATA = 8'h07;
    localparam logic [7:0] LEN_FIXED_REQ = 8'h08;
    localparam logic [8:0] LEN_MANY_HDR = 9'h009;
    localparam logic [7:0] LEN_ECHO = 8'h06;
    localparam logic [7:0] LEN_EXC = 8'h03;
    localparam logic [7:0] LEN_RD_HDR = 8'h03;
    localparam logic [15:0] MAX_RD_QTY = 16'h007D;
    localparam logic [15:0] MAX_WR_QTY = 16'h007B;
    // Checksum
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    typedef enum logic [2:0] {
        ST_RECV,
        ST_CHECK,
        ST_ACC,
        ST_GAP,
        ST_TAKE,
        ST_SEND,
        ST_DRAIN
    } state_t;

    function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc16_byte
endpackage : modbus_pkg

// ==== rtl/serial_rx.sv ====
// Asynchronous character receiver, start bit, eight data bits, two stop bits
`timescale 1ns/1ps
`default_nettype none
module serial_rx #(
    parameter int unsigned BIT_CYCLES = modbus_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Line
    input wire logic rxd_in,
    // Received characters
    output logic [7:0] byte_out,
    output logic byte_valid_out,
    output logic frame_err_out,
    output logic busy_out
);
    localparam logic [modbus_pkg::CW-1:0] FULL = modbus_pkg::CW'(BIT_CYCLES - 1);
    localparam logic [modbus_pkg::CW-1:0] HALF = modbus_pkg::CW'(BIT_CYCLES / 2);
    localparam logic [3:0] LAST = 4'(modbus_pkg::CHAR_BITS - 1);
    localparam logic [3:0] FIRST_STOP = 4'(modbus_pkg::DATA_BITS + 1);

    logic sync1_ff;
    logic sync2_ff;
    logic [modbus_pkg::CW-1:0] cnt_ff;
    logic [3:0] bit_ff;
    logic [7:0] shift_ff;

    // Pin is asynchronous to the system clock
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= rxd_in;
            sync2_ff <= sync1_ff;
        end
    end

    // Sample each bit at its centre
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            busy_out <= 1'b0;
            byte_out <= '0;
            byte_valid_out <= 1'b0;
            frame_err_out <= 1'b0;
        end else begin
            byte_valid_out <= 1'b0;
            frame_err_out <= 1'b0;
            if (!busy_out) begin
                if (!sync2_ff) begin
                    busy_out <= 1'b1;
                    cnt_ff <= HALF;
                    bit_ff <= '0;
                end
            end else if (cnt_ff != '0) begin
                cnt_ff <= cnt_ff - 1'b1;
            end else begin
                cnt_ff <= FULL;
                bit_ff <= bit_ff + 1'b1;
                if (bit_ff == 4'h0) begin
                    // Glitch shorter than half a bit is dropped
                    if (sync2_ff) begin
                        busy_out <= 1'b0;
                    end
                end else if (bit_ff < FIRST_STOP) begin
                    shift_ff <= {sync2_ff, shift_ff[7:1]}; // RULE_02
                end else if (!sync2_ff) begin
                    busy_out <= 1'b0;
                    frame_err_out <= 1'b1; // RULE_02
                end else if (bit_ff == LAST) begin
                    busy_out <= 1'b0;
                    byte_out <= shift_ff;
                    byte_valid_out <= 1'b1;
                end
            end
        end
    end
endmodule : serial_rx
`default_nettype wire

// ==== rtl/serial_tx.sv ====
// Asynchronous character transmitter, start bit, eight data bits, two stop bits
`timescale 1ns/1ps
`default_nettype none
module serial_tx #(
    parameter int unsigned BIT_CYCLES = modbus_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Characters to send
    input wire logic [7:0] byte_in,
    input wire logic valid_in,
    output logic ready_out,
    // Line
    output logic txd_out,
    output logic busy_out
);
    localparam logic [modbus_pkg::CW-1:0] FULL = modbus_pkg::CW'(BIT_CYCLES - 1);
    localparam logic [3:0] NBITS = 4'(modbus_pkg::CHAR_BITS);

    logic [modbus_pkg::CW-1:0] cnt_ff;
    logic [3:0] left_ff;
    logic [10:0] shift_ff;

    assign ready_out = !busy_out;

    // Busy stays high through the whole second stop bit
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            busy_out <= 1'b0;
            txd_out <= 1'b1;
        end else if (!busy_out) begin
            txd_out <= 1'b1;
            if (valid_in) begin
                busy_out <= 1'b1;
                cnt_ff <= FULL;
                left_ff <= NBITS - 1'b1;
                shift_ff <= {2'b11, byte_in, 1'b0}; // RULE_02
                txd_out <= 1'b0;
            end
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end else if (left_ff == 4'h0) begin
            busy_out <= 1'b0;
            txd_out <= 1'b1;
        end else begin
            cnt_ff <= FULL;
            left_ff <= left_ff - 1'b1;
            shift_ff <= {1'b1, shift_ff[10:1]};
            txd_out <= shift_ff[1];
        end
    end
endmodule : serial_tx
`default_nettype wire

// ==== rtl/modbus_rtu_slave_frames.sv ====
// RTU slave frame engine: receive, check, serve registers, reply
//
// Overview of operation
// RULE_01 - Line runs at 2400 bit/s from reset onward.
// RULE_02 - Characters are one start, eight data, two stop bits, no parity.
// RULE_03 - Half duplex; slave only transmits in answer to a master frame.
// RULE_04 - Frame ends after more than 1.5 character times of idle line.
// RULE_05 - Frame is address, function, 0 to 251 data bytes, two CRC bytes.
// RULE_06 - Address zero is served as broadcast with no reply; code serves only 06 and 10 broadcasts and drops the others.
// RULE_07 - Only own address or broadcast frames are served.
// RULE_08 - Every reply carries the slave's own address.
// RULE_09 - Read request: code 03, start address, count, high bytes first.
// RULE_10 - Read reply: code 03, byte count, register words high byte first.
// RULE_11 - Single write request: code 06, address, value, high bytes first.
// RULE_12 - Single write reply echoes code 06, address and value.
// RULE_13 - Multi write request: code 10, start, count, byte count, words.
// RULE_14 - Multi write reply: code 10, start address and count.
// RULE_15 - Exception reply: code plus 80, one exception code, CRC.
// RULE_16 - Address field is the first register; registers follow consecutively.
// RULE_17 - CRC16 reflected polynomial A001, start FFFF, from address byte.
// RULE_18 - Frames whose CRC does not match are discarded.
// RULE_19 - Multi write byte count equals data length in bytes.
// RULE_20 - Unknown function gives exception 01; bad CRC or foreign address silent.
// RULE_21 - Bus driver released after the last stop bit of the reply.
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_frames #(
    parameter int unsigned BIT_CYCLES = modbus_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Line transceiver
    input wire logic rxd_in,
    output logic txd_out,
    output logic drv_en_out,
    // Own slave address, taken while reset is held
    input wire logic [7:0] own_addr_in,
    // Register access
    output logic reg_rd_out,
    output logic reg_wr_out,
    output logic [15:0] reg_addr_out,
    output logic [15:0] reg_wdata_out,
    input wire logic [15:0] reg_rdata_in,
    input wire logic [7:0] reg_exc_in
);
    localparam int unsigned GAP_CYCLES =
        BIT_CYCLES * modbus_pkg::CHAR_BITS * modbus_pkg::GAP_HALF_CHARS / 2;
    localparam logic [modbus_pkg::CW-1:0] GAP_LIMIT = modbus_pkg::CW'(GAP_CYCLES);

    modbus_pkg::state_t state_ff;
    logic [7:0] own_addr_ff;
    logic [7:0] rx_buf [0:254];
    logic [15:0] rd_word [0:124];
    logic [7:0] rx_len_ff;
    logic [15:0] rx_crc_ff;
    logic rx_bad_ff;
    logic [modbus_pkg::CW-1:0] idle_cnt_ff;
    logic bcast_ff;
    logic exc_ff;
    logic [7:0] exc_code_ff;
    logic [7:0] tx_len_ff;
    logic [7:0] idx_ff;
    logic [15:0] tx_crc_ff;
    logic [15:0] addr_ff;
    logic [6:0] wcnt_ff;
    logic [6:0] wtot_ff;

    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_ferr;
    logic rx_busy;
    logic tx_ready;
    logic tx_busy;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_take;
    logic receiving;

    logic [7:0] fc;
    logic [15:0] start_w;
    logic [15:0] qty_w;
    logic [7:0] bcnt;
    logic [7:0] data_pos;
    logic [7:0] rd_k;
    logic [15:0] rd_w;

    assign fc = rx_buf[modbus_pkg::POS_FC];
    assign start_w = {rx_buf[2], rx_buf[3]}; // RULE_09
    assign qty_w = {rx_buf[4], rx_buf[5]}; // RULE_11
    assign bcnt = rx_buf[6]; // RULE_13
    assign data_pos = modbus_pkg::POS_DATA + {wcnt_ff, 1'b0};
    assign receiving = (state_ff == modbus_pkg::ST_RECV);

    serial_rx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_rx (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .rxd_in(rxd_in),
        .byte_out(rx_byte),
        .byte_valid_out(rx_valid),
        .frame_err_out(rx_ferr),
        .busy_out(rx_busy)
    );

    serial_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .byte_in(tx_byte),
        .valid_in(tx_valid),
        .ready_out(tx_ready),
        .txd_out(txd_out),
        .busy_out(tx_busy)
    );

    // Change of address only takes effect through reset
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            own_addr_ff <= own_addr_in;
        end
    end

    // Frame collection; echoes heard while answering are dropped
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || !receiving) begin
            rx_len_ff <= '0;
            rx_crc_ff <= modbus_pkg::CRC_INIT; // RULE_17
            rx_bad_ff <= 1'b0;
        end else if (rx_ferr) begin
            rx_bad_ff <= 1'b1;
        end else if (rx_valid) begin
            if (rx_len_ff == modbus_pkg::MAX_FRAME) begin
                rx_bad_ff <= 1'b1; // RULE_05
            end else begin
                rx_len_ff <= rx_len_ff + 1'b1;
                rx_crc_ff <= modbus_pkg::crc16_byte(rx_crc_ff, rx_byte); // RULE_17
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (receiving && rx_valid && rx_len_ff != modbus_pkg::MAX_FRAME) begin
            rx_buf[rx_len_ff] <= rx_byte;
        end
    end

    // Idle time since the last character
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || rx_busy || !receiving) begin
            idle_cnt_ff <= '0;
        end else if (idle_cnt_ff <= GAP_LIMIT) begin
            idle_cnt_ff <= idle_cnt_ff + 1'b1;
        end
    end

    // Read data held until the reply is sent
    always_ff @(posedge clk_sys_in) begin
        if (state_ff == modbus_pkg::ST_TAKE && fc == modbus_pkg::FC_READ) begin
            rd_word[wcnt_ff] <= reg_rdata_in; // RULE_16
        end
    end

    // Reply byte selection
    always_comb begin
        rd_k = idx_ff - modbus_pkg::LEN_RD_HDR;
        rd_w = rd_word[rd_k[7:1]];
        if (idx_ff == tx_len_ff) begin
            tx_byte = tx_crc_ff[7:0]; // RULE_17
        end else if (idx_ff > tx_len_ff) begin
            tx_byte = tx_crc_ff[15:8];
        end else if (idx_ff == 8'h00) begin
            tx_byte = own_addr_ff; // RULE_08
        end else if (idx_ff == modbus_pkg::POS_FC) begin
            tx_byte = exc_ff ? (fc | modbus_pkg::FC_EXC_FLAG) : fc; // RULE_15
        end else if (exc_ff) begin
            tx_byte = exc_code_ff; // RULE_15
        end else if (fc == modbus_pkg::FC_READ) begin
            if (idx_ff == 8'h02) begin
                tx_byte = {qty_w[6:0], 1'b0}; // RULE_10
            end else begin
                tx_byte = rd_k[0] ? rd_w[7:0] : rd_w[15:8]; // RULE_10
            end
        end else begin
            tx_byte = rx_buf[idx_ff]; // RULE_12 RULE_14
        end
    end

    assign tx_valid = (state_ff == modbus_pkg::ST_SEND) && !bcast_ff; // RULE_06
    assign tx_take = tx_valid && tx_ready;
    assign drv_en_out = tx_valid || (state_ff == modbus_pkg::ST_DRAIN); // RULE_21 RULE_03

    // Main sequence
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_ff <= modbus_pkg::ST_RECV;
            bcast_ff <= 1'b0;
            exc_ff <= 1'b0;
            reg_rd_out <= 1'b0;
            reg_wr_out <= 1'b0;
            reg_addr_out <= '0;
            reg_wdata_out <= '0;
        end else begin
            case (state_ff)
                modbus_pkg::ST_RECV: begin
                    if (rx_len_ff != '0 && idle_cnt_ff > GAP_LIMIT) begin
                        state_ff <= modbus_pkg::ST_CHECK; // RULE_04
                    end
                end
                modbus_pkg::ST_CHECK: begin
                    exc_ff <= 1'b0;
                    idx_ff <= '0;
                    tx_crc_ff <= modbus_pkg::CRC_INIT;
                    addr_ff <= start_w; // RULE_16
                    wcnt_ff <= '0;
                    bcast_ff <= (rx_buf[0] == modbus_pkg::ADDR_BCAST); // RULE_06
                    if (rx_bad_ff || rx_len_ff < modbus_pkg::MIN_FRAME
                            || rx_crc_ff != modbus_pkg::CRC_GOOD) begin
                        state_ff <= modbus_pkg::ST_RECV; // RULE_18 RULE_20
                    end else if (rx_buf[0] != own_addr_ff
                            && rx_buf[0] != modbus_pkg::ADDR_BCAST) begin
                        state_ff <= modbus_pkg::ST_RECV; // RULE_07 RULE_20
                    end else begin
                        case (fc)
                            modbus_pkg::FC_READ: begin
                                wtot_ff <= qty_w[6:0];
                                tx_len_ff <= modbus_pkg::LEN_RD_HDR + {qty_w[6:0], 1'b0};
                                if (rx_len_ff != modbus_pkg::LEN_FIXED_REQ || qty_w == '0
                                        || qty_w > modbus_pkg::MAX_RD_QTY) begin
                                    exc_ff <= 1'b1;
                                    exc_code_ff <= modbus_pkg::EXC_VALUE;
                                    tx_len_ff <= modbus_pkg::LEN_EXC;
                                    state_ff <= modbus_pkg::ST_SEND;
                                end else begin
                                    state_ff <= modbus_pkg::ST_ACC; // RULE_09
                                end
                            end
                            modbus_pkg::FC_WR_ONE: begin
                                wtot_ff <= 7'h01;
                                tx_len_ff <= modbus_pkg::LEN_ECHO;
                                if (rx_len_ff != modbus_pkg::LEN_FIXED_REQ) begin
                                    exc_ff <= 1'b1;
                                    exc_code_ff <= modbus_pkg::EXC_VALUE;
                                    tx_len_ff <= modbus_pkg::LEN_EXC;
                                    state_ff <= modbus_pkg::ST_SEND;
                                end else begin
                                    state_ff <= modbus_pkg::ST_ACC; // RULE_11
                                end
                            end
                            modbus_pkg::FC_WR_MANY: begin
                                wtot_ff <= qty_w[6:0];
                                tx_len_ff <= modbus_pkg::LEN_ECHO;
                                if (qty_w == '0 || qty_w > modbus_pkg::MAX_WR_QTY
                                        || {qty_w[14:0], 1'b0} != {8'h00, bcnt}
                                        || {1'b0, rx_len_ff}
                                        != modbus_pkg::LEN_MANY_HDR + {1'b0, bcnt}) begin
                                    exc_ff <= 1'b1; // RULE_19
                                    exc_code_ff <= modbus_pkg::EXC_VALUE;
                                    tx_len_ff <= modbus_pkg::LEN_EXC;
                                    state_ff <= modbus_pkg::ST_SEND;
                                end else begin
                                    state_ff <= modbus_pkg::ST_ACC; // RULE_13
                                end
                            end
                            default: begin
                                exc_ff <= 1'b1;
                                exc_code_ff <= modbus_pkg::EXC_FUNC; // RULE_20
                                tx_len_ff <= modbus_pkg::LEN_EXC;
                                state_ff <= modbus_pkg::ST_SEND; // RULE_15
                            end
                        endcase
                        if (rx_buf[0] == modbus_pkg::ADDR_BCAST && fc != modbus_pkg::FC_WR_ONE
                                && fc != modbus_pkg::FC_WR_MANY) begin
                            state_ff <= modbus_pkg::ST_RECV; // RULE_06
                        end
                    end
                end
                modbus_pkg::ST_ACC: begin
                    reg_addr_out <= addr_ff; // RULE_16
                    reg_rd_out <= (fc == modbus_pkg::FC_READ);
                    reg_wr_out <= (fc != modbus_pkg::FC_READ);
                    if (fc == modbus_pkg::FC_WR_ONE) begin
                        reg_wdata_out <= qty_w;
                    end else begin
                        reg_wdata_out <= {rx_buf[data_pos], rx_buf[data_pos + 8'h01]}; // RULE_13
                    end
                    state_ff <= modbus_pkg::ST_GAP;
                end
                modbus_pkg::ST_GAP: begin
                    reg_rd_out <= 1'b0;
                    reg_wr_out <= 1'b0;
                    state_ff <= modbus_pkg::ST_TAKE;
                end
                modbus_pkg::ST_TAKE: begin
                    addr_ff <= addr_ff + 16'h0001; // RULE_16
                    wcnt_ff <= wcnt_ff + 7'h01;
                    if (reg_exc_in != '0) begin
                        // Registers already written stay written
                        exc_ff <= 1'b1;
                        exc_code_ff <= reg_exc_in; // RULE_15
                        tx_len_ff <= modbus_pkg::LEN_EXC;
                        state_ff <= modbus_pkg::ST_SEND;
                    end else if (wcnt_ff + 7'h01 == wtot_ff) begin
                        state_ff <= modbus_pkg::ST_SEND;
                    end else begin
                        state_ff <= modbus_pkg::ST_ACC;
                    end
                end
                modbus_pkg::ST_SEND: begin
                    if (bcast_ff) begin
                        state_ff <= modbus_pkg::ST_RECV; // RULE_06
                    end
                    if (tx_take) begin
                        idx_ff <= idx_ff + 8'h01;
                        if (idx_ff < tx_len_ff) begin
                            tx_crc_ff <= modbus_pkg::crc16_byte(tx_crc_ff, tx_byte); // RULE_17
                        end
                        if (idx_ff == tx_len_ff + 8'h01) begin
                            state_ff <= modbus_pkg::ST_DRAIN;
                        end
                    end
                end
                modbus_pkg::ST_DRAIN: begin
                    if (!tx_busy) begin
                        state_ff <= modbus_pkg::ST_RECV; // RULE_21
                    end
                end
                default: begin
                    state_ff <= modbus_pkg::ST_RECV;
                end
            endcase
        end
    end
endmodule : modbus_rtu_slave_frames
`default_nettype wire

// ==== dv/rtu_monitor.sv ====
// Port checker for the RTU slave frame engine
`timescale 1ns/1ps
`default_nettype none
module rtu_monitor (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Observed ports
    input wire logic txd_out,
    input wire logic drv_en_out,
    input wire logic reg_rd_out,
    input wire logic reg_wr_out,
    input wire logic [15:0] reg_addr_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    // Needs BIT_CYCLES of 8 or more
    idle_high_a: assert property (!drv_en_out |-> txd_out) else $error("idle low");
    reset_quiet_a: assert property ($fell(srst_in) |-> txd_out && !drv_en_out) else $error("rst");
    start_low_a: assert property ($rose(drv_en_out) |=> !txd_out [*8]) else $error("start");
    stop_end_a: assert property ($fell(drv_en_out) |-> $past(txd_out, 8)) else $error("stop");
    rd_pulse_a: assert property (reg_rd_out |=> !reg_rd_out [*2]) else $error("rd pulse");
    wr_pulse_a: assert property (reg_wr_out |=> !reg_wr_out [*2]) else $error("wr pulse");
    one_strobe_a: assert property (!(reg_rd_out && reg_wr_out)) else $error("both strobes");
    tx_no_acc_a: assert property (drv_en_out |-> !reg_rd_out && !reg_wr_out) else $error("acc");
    next_addr_a: assert property (reg_rd_out ##3 reg_rd_out |->
        reg_addr_out == $past(reg_addr_out, 3) + 16'h0001) else $error("addr step");
endmodule : rtu_monitor
bind modbus_rtu_slave_frames rtu_monitor u_rtu_monitor (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .txd_out(txd_out), .drv_en_out(drv_en_out), .reg_rd_out(reg_rd_out),
    .reg_wr_out(reg_wr_out), .reg_addr_out(reg_addr_out));
`default_nettype wire

// ==== dv/rtu_master_model.sv ====
// Bus master model: sends request frames, collects reply characters
`timescale 1ns/1ps
`default_nettype none
module rtu_master_model #(
    parameter int BC = 16
) (
    // Clock
    input wire logic clk_sys_in,
    // Line
    input wire logic line_in,
    output logic txd_out
);
    logic [7:0] got[$];
    logic [9:0] b;
    initial txd_out = 1'b1;
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction : crc
    task automatic send_byte(input logic [7:0] v);
        logic [10:0] f;
        f = {2'b11, v, 1'b0};
        for (int i = 0; i < 11; i++) begin
            #1 txd_out = f[i];
            repeat (BC) @(posedge clk_sys_in);
        end
    endtask : send_byte
    // Only between replies, never fighting the line
    task automatic send_frame(input logic [7:0] q[$], input bit bad);
        logic [15:0] c;
        c = crc(q) ^ {15'h0000, bad};
        q = {q, c[7:0], c[15:8]};
        foreach (q[i]) send_byte(q[i]);
    endtask : send_frame
    always begin
        @(negedge line_in);
        repeat (BC / 2) @(posedge clk_sys_in);
        for (int i = 0; i < 10; i++) begin
            repeat (BC) @(posedge clk_sys_in);
            b[i] = line_in;
        end
        if (b[9:8] == 2'b11) got.push_back(b[7:0]);
    end
endmodule : rtu_master_model
`default_nettype wire

// ==== dv/modbus_rtu_slave_frames_test.sv ====
// Self-checking bench for the RTU slave frame engine
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_frames_test;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] own_addr_in = 8'h00;
    logic [15:0] reg_rdata_in = 16'h0000;
    logic [7:0] reg_exc_in = 8'h00;
    logic rxd, txd_out, drv_en_out, reg_rd_out, reg_wr_out, line, rd_seen;
    logic [15:0] reg_addr_out, reg_wdata_out, wa, wd, s, n, w;
    logic [15:0] exc_at = 16'hFFFF;
    logic [31:0] seed = 32'hFE2E435F;
    logic [7:0] a, e[$], f[$], z[$];
    int fails = 0;
    int cmp_count = 0;
    always #2 clk_sys_in = ~clk_sys_in;
    assign line = drv_en_out ? txd_out : 1'b1;
    modbus_rtu_slave_frames #(.BIT_CYCLES(16)) u_modbus_rtu_slave_frames (.clk_sys_in(clk_sys_in),
        .srst_in(srst_in), .rxd_in(rxd), .txd_out(txd_out), .drv_en_out(drv_en_out),
        .own_addr_in(own_addr_in), .reg_rd_out(reg_rd_out), .reg_wr_out(reg_wr_out),
        .reg_addr_out(reg_addr_out), .reg_wdata_out(reg_wdata_out),
        .reg_rdata_in(reg_rdata_in), .reg_exc_in(reg_exc_in));
    rtu_master_model #(.BC(16)) u_rtu_master_model (.clk_sys_in(clk_sys_in), .line_in(line),
        .txd_out(rxd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] rval(input logic [15:0] ad);
        return ad ^ 16'hA5C3;
    endfunction : rval
    // Read data shows only in the answer cycle, inverted otherwise
    always @(posedge clk_sys_in) begin
        #1 reg_rdata_in = rd_seen ? rval(reg_addr_out) : ~rval(reg_addr_out);
        rd_seen = reg_rd_out;
        if (reg_wr_out === 1'b1) {wa, wd} = {reg_addr_out, reg_wdata_out};
        reg_exc_in = (reg_addr_out === exc_at) ? 8'h02 : 8'h00;
    end
    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] g, x);
        cmp_count++;
        if (g !== x) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    task automatic ask(input logic [7:0] q[$], input logic [7:0] x[$], input bit bad);
        logic [15:0] c;
        int i;
        c = u_rtu_master_model.crc(x);
        if (x.size() > 0) x = {x, c[7:0], c[15:8]};
        u_rtu_master_model.send_frame(q, bad);
        for (i = 0; i < 6000; i++) begin
            @(posedge clk_sys_in);
            if (i > 600 && !drv_en_out && u_rtu_master_model.got.size() == x.size()) break;
        end
        if (i == 6000) begin
            fails++;
            print_verdict();
        end
        foreach (x[k]) chk(u_rtu_master_model.got[k], x[k]);
        if (x.size() > 0) chk(u_rtu_master_model.crc(u_rtu_master_model.got), 16'h0000);
        u_rtu_master_model.got.delete();
    endtask : ask
    initial begin
        own_addr_in = 8'(rnd() % 247 + 1);
        repeat (3) @(posedge clk_sys_in);
        #1 srst_in = 1'b0;
        @(posedge clk_sys_in);
        a = own_addr_in;
        for (int k = 0; k < 4; k++) begin
            s = 16'(rnd());
            n = 16'(rnd() % 4 + 1);
            e = '{a, 8'h03, 8'(2 * n)};
            for (int i = 0; i < n; i++) begin
                w = rval(s + 16'(i));
                e = {e, w[15:8], w[7:0]};
            end
            ask('{a, 8'h03, s[15:8], s[7:0], n[15:8], n[7:0]}, e, 1'b0);
        end
        {s, n} = rnd();
        f = '{a, 8'h06, s[15:8], s[7:0], n[15:8], n[7:0]};
        ask(f, f, 1'b0);
        chk(wd, n);
        {s, n} = rnd();
        ask('{8'h00, 8'h06, s[15:8], s[7:0], n[15:8], n[7:0]}, z, 1'b0);
        chk(wd, n);
        ask('{a, 8'h10, s[15:8], s[7:0], 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, n[15:8], n[7:0]},
            '{a, 8'h10, s[15:8], s[7:0], 8'h00, 8'h02}, 1'b0);
        chk(wa, s + 16'h0001);
        chk(wd, n);
        ask('{a, 8'h10, s[15:8], s[7:0], 8'h00, 8'h02, 8'h03, 8'h12, 8'h34, 8'h56, 8'h78},
            '{a, 8'h90, 8'h03}, 1'b0);
        ask('{a, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, '{a, 8'h87, 8'h01}, 1'b0);
        ask('{a, 8'h03, s[15:8], s[7:0], 8'h00, 8'h00}, '{a, 8'h83, 8'h03}, 1'b0);
        exc_at = s;
        ask('{a, 8'h03, s[15:8], s[7:0], 8'h00, 8'h01}, '{a, 8'h83, 8'h02}, 1'b0);
        exc_at = 16'hFFFF;
        ask('{a, 8'h03, s[15:8], s[7:0], 8'h00, 8'h01}, z, 1'b1);
        ask('{a + 8'h01, 8'h03, s[15:8], s[7:0], 8'h00, 8'h01}, z, 1'b0);
        print_verdict();
    end
endmodule : modbus_rtu_slave_frames_test
`default_nettype wire
